// [hdl/nfo_pkg.sv]
// nfo_pkg: constants, types and register map of the nand feature and one-time-area controller
package nfo_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int T_STROBE_NS = 20;
	localparam int T_HOLD_NS = 20;
	localparam int T_WP_SETUP_NS = 100;
	localparam int T_BUSY_SETTLE_NS = 100;
	localparam int T_RESET_US = 5;
	localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int WP_SETUP_CYC = (T_WP_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int BUSY_SETTLE_CYC = (T_BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int RESET_CYC = T_RESET_US * CLK_MHZ;
	localparam int SYNC_STAGES = 2;
	// ------------------------------------------------------------
	// device commands and addresses
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] CMD_OTP_PROG = 8'hA0;
	localparam logic [7:0] CMD_OTP_PROTECT = 8'hA5;
	localparam logic [7:0] CMD_OTP_READ = 8'hAF;
	localparam logic [7:0] CMD_CONFIRM_PROG = 8'h10;
	localparam logic [7:0] CMD_CONFIRM_READ = 8'h30;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_MODE = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] FEAT_ADDR_DRIVE = 8'h80;
	localparam logic [7:0] FEAT_ADDR_PULLDOWN = 8'h81;
	localparam logic [1:0] STRENGTH_FULL = 2'h0;
	localparam logic [31:0] PROTECT_ADDR = 32'h0001_0000;
	localparam logic [11:0] OTP_PAGE_BYTES = 12'h840;
	localparam int OTP_PAGES = 10;
	localparam logic [7:0] OTP_FIRST_PAGE = 8'h02;
	localparam logic [2:0] MAX_PARTIAL = 3'h4;
	localparam logic [11:0] FEAT_PARAMS = 12'h004;
	localparam logic [11:0] ADDR_CYC_FEAT = 12'h001;
	localparam logic [11:0] ADDR_CYC_OTP = 12'h004;
	localparam int SR_PASS_FAIL = 0;
	localparam int SR_READY = 6;
	localparam int SR_UNPROT = 7;
	// ------------------------------------------------------------
	// controller registers
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_LEN = 8'h08;
	localparam logic [7:0] REG_FEAT = 8'h0C;
	localparam logic [7:0] REG_TXDATA = 8'h10;
	localparam logic [7:0] REG_RXDATA = 8'h14;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_WP = 8'h1C;
	localparam int CTRL_POLL = 4;
	localparam int WP_ENABLE = 0;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_GET_FEAT = 4'h1, OP_SET_FEAT = 4'h2, OP_OTP_PROG = 4'h3,
		OP_OTP_PROTECT = 4'h4, OP_OTP_READ = 4'h5, OP_STATUS = 4'h6, OP_RESET = 4'h7,
		OP_DATA_READ = 4'h8
	} nfo_op_e;
	typedef enum logic [1:0] {CY_CMD = 2'h0, CY_ADDR = 2'h1, CY_DWR = 2'h2, CY_DRD = 2'h3} nfo_cyc_e;
	typedef enum logic [2:0] {CE_IDLE = 3'h1, CE_LOW = 3'h2, CE_HIGH = 3'h4} nfo_cyc_state_e;
	typedef struct packed {
		nfo_cyc_e kind;
		logic [7:0] data;
	} nfo_cyc_s;
	typedef struct packed {
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
	} nfo_strobe_s;
endpackage

// [hdl/nfo_sync.sv]
// nfo_sync: two-flop synchronisers for pin inputs
`timescale 1ns/1ps
module nfo_sync #(
	parameter int W = 9
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					meta_ff[i] <= 1'b0;
					q_ff[i] <= 1'b0;
				end else begin
					meta_ff[i] <= d[i];
					q_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign q = q_ff;
endmodule

// [hdl/nfo_cycle.sv]
// nfo_cycle: one command, address or data strobe cycle on the flash pins
`timescale 1ns/1ps
module nfo_cycle import nfo_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire nfo_cyc_s req,
	input wire logic [7:0] io_sync,
	output nfo_strobe_s strobe,
	output logic [7:0] io_o,
	output logic io_oe,
	output logic done,
	output logic [7:0] rdata
);
	// read low phase covers synchroniser latency before sampling
	localparam logic [7:0] LOW_WR = 8'(STROBE_CYC - 1);
	localparam logic [7:0] LOW_RD = 8'(STROBE_CYC + SYNC_STAGES - 1);
	localparam logic [7:0] HOLD = 8'(HOLD_CYC - 1);

	nfo_cyc_state_e state_ff;
	nfo_strobe_s strobe_ff;
	logic [7:0] io_o_ff;
	logic io_oe_ff;
	logic done_ff;
	logic [7:0] rdata_ff;
	logic [7:0] cnt_ff;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= CE_IDLE;
			strobe_ff <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1};
			io_o_ff <= 8'h00;
			io_oe_ff <= 1'b0;
			done_ff <= 1'b0;
			rdata_ff <= 8'h00;
			cnt_ff <= 8'h00;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				CE_IDLE: begin
					if (start) begin
						strobe_ff.cle <= (req.kind == CY_CMD);
						strobe_ff.ale <= (req.kind == CY_ADDR);
						if (req.kind == CY_DRD) begin
							strobe_ff.re_n <= 1'b0;
							io_oe_ff <= 1'b0;
							cnt_ff <= LOW_RD;
						end else begin
							// device latches the byte on the rising write strobe
							strobe_ff.we_n <= 1'b0;
							io_oe_ff <= 1'b1;
							io_o_ff <= req.data;
							cnt_ff <= LOW_WR;
						end
						state_ff <= CE_LOW;
					end
				end
				CE_LOW: begin
					if (cnt_ff == 8'h00) begin
						if (!strobe_ff.re_n) begin
							rdata_ff <= io_sync;
						end
						strobe_ff.we_n <= 1'b1;
						strobe_ff.re_n <= 1'b1;
						cnt_ff <= HOLD;
						state_ff <= CE_HIGH;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				CE_HIGH: begin
					if (cnt_ff == 8'h00) begin
						strobe_ff.cle <= 1'b0;
						strobe_ff.ale <= 1'b0;
						io_oe_ff <= 1'b0;
						done_ff <= 1'b1;
						state_ff <= CE_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				default: begin
					state_ff <= CE_IDLE;
				end
			endcase
		end
	end

	assign strobe = strobe_ff;
	assign io_o = io_o_ff;
	assign io_oe = io_oe_ff;
	assign done = done_ff;
	assign rdata = rdata_ff;
endmodule

// [hdl/nfo_ctrl.sv]
// nfo_ctrl: host controller for nand feature access, one-time area and write protect
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module nfo_ctrl import nfo_pkg::*; #(
	parameter int ADR_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic nand_re_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_o,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_i,
	input wire logic ready_busy_n
);
	// ------------------------------------------------------------
	// types, helpers
	// ------------------------------------------------------------
	typedef enum logic [11:0] {
		S_IDLE = 12'h001, S_WP = 12'h002, S_CMD = 12'h004, S_ADDR = 12'h008,
		S_DWR = 12'h010, S_CONF = 12'h020, S_SETTLE = 12'h040, S_WAIT = 12'h080,
		S_SCMD = 12'h100, S_SRD = 12'h200, S_RESTORE = 12'h400, S_DRD = 12'h800
	} nfo_seq_e;

	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
		byte_of = w[8*idx +: 8];
	endfunction

	function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		lanes = r;
	endfunction

	localparam logic [15:0] WP_SETUP = 16'(WP_SETUP_CYC);
	localparam logic [15:0] SETTLE = 16'(BUSY_SETTLE_CYC);
	localparam logic [15:0] RST_WAIT = 16'(RESET_CYC);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	nfo_seq_e state_ff;
	nfo_op_e op_ff;
	logic ack_ff;
	logic [31:0] rd_ff;
	logic [31:0] addr_ff;
	logic [11:0] len_ff;
	logic [1:0] strength_ff;
	logic [31:0] feat_rd_ff;
	logic [7:0] tx_data_ff;
	logic tx_valid_ff;
	logic [7:0] rx_data_ff;
	logic rx_valid_ff;
	logic wp_en_ff;
	logic wp_n_ff;
	logic ce_n_ff;
	logic poll_ff;
	logic poll_phase_ff;
	logic err_ff;
	logic feat_mode_ff;
	logic need_restore_ff;
	logic [7:0] stat_ff;
	logic [11:0] cnt_ff;
	logic [15:0] timer_ff;
	logic pend_ff;
	logic cy_start_ff;
	nfo_cyc_s cy_req_ff;
	logic [2:0] part_ff [OTP_PAGES];

	logic [8:0] sync_q;
	logic rb_ready;
	logic [7:0] io_sync;
	nfo_strobe_s strobe;
	logic cy_done;
	logic [7:0] cy_rdata;
	logic bus_hit;
	logic bus_wr;
	logic bus_rd;
	logic start_go;
	logic start_ok;
	logic [7:0] page_idx;
	logic iss_en;
	nfo_cyc_s iss_req;
	logic tx_take;
	logic rx_load;
	logic [11:0] n_addr;
	logic [11:0] n_data;

	assign bus_hit = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign bus_wr = bus_hit & wb_we_i;
	assign bus_rd = bus_hit & ~wb_we_i;
	assign start_go = bus_wr && (wb_adr_i[7:0] == REG_CTRL) && wb_sel_i[0] && (state_ff == S_IDLE);
	assign rb_ready = sync_q[8];
	assign io_sync = sync_q[7:0];
	assign page_idx = 8'(addr_ff[23:16] - OTP_FIRST_PAGE);
	assign tx_take = (state_ff == S_DWR) && (op_ff == OP_OTP_PROG) && !pend_ff && tx_valid_ff;
	assign rx_load = (state_ff == S_DRD) && (op_ff == OP_DATA_READ) && cy_done;
	assign n_addr = (op_ff == OP_GET_FEAT || op_ff == OP_SET_FEAT) ? ADDR_CYC_FEAT : ADDR_CYC_OTP;
	assign n_data = (op_ff == OP_SET_FEAT || op_ff == OP_GET_FEAT) ? FEAT_PARAMS : len_ff;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	nfo_sync #(.W(9)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d({ready_busy_n, nand_io_i}),
		.q(sync_q)
	);

	nfo_cycle u_cycle (
		.clk(clk),
		.reset_n(reset_n),
		.start(cy_start_ff),
		.req(cy_req_ff),
		.io_sync(io_sync),
		.strobe(strobe),
		.io_o(nand_io_o),
		.io_oe(nand_io_oe),
		.done(cy_done),
		.rdata(cy_rdata)
	);

	// ------------------------------------------------------------
	// start checks
	// ------------------------------------------------------------
	always_comb begin
		start_ok = 1'b1;
		case (nfo_op_e'(wb_dat_i[3:0]))
			OP_GET_FEAT, OP_SET_FEAT: begin
				start_ok = (addr_ff[7:0] == FEAT_ADDR_DRIVE) ||
					(addr_ff[7:0] == FEAT_ADDR_PULLDOWN);
			end
			OP_OTP_PROG: begin
				// a start outside page range, length or partial count is refused
				start_ok = (len_ff != 12'h000) && (len_ff <= OTP_PAGE_BYTES) &&
					(addr_ff[31:24] == 8'h00) && (page_idx < 8'(OTP_PAGES)) &&
					(part_ff[page_idx[3:0]] < MAX_PARTIAL);
			end
			OP_OTP_PROTECT, OP_OTP_READ, OP_STATUS, OP_RESET, OP_DATA_READ: begin
				start_ok = 1'b1;
			end
			default: begin
				start_ok = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// cycle issue per state
	// ------------------------------------------------------------
	always_comb begin
		iss_en = 1'b1;
		iss_req = '{kind: CY_CMD, data: CMD_STATUS};
		case (state_ff)
			S_CMD: begin
				case (op_ff)
					OP_GET_FEAT: iss_req.data = CMD_GET_FEAT;
					OP_SET_FEAT: iss_req.data = CMD_SET_FEAT;
					OP_OTP_PROG: iss_req.data = CMD_OTP_PROG;
					OP_OTP_PROTECT: iss_req.data = CMD_OTP_PROTECT;
					OP_OTP_READ: iss_req.data = CMD_OTP_READ;
					OP_RESET: iss_req.data = CMD_RESET;
					OP_DATA_READ: iss_req.data = CMD_READ_MODE;
					default: iss_req.data = CMD_STATUS;
				endcase
			end
			S_ADDR: begin
				iss_req.kind = CY_ADDR;
				iss_req.data = byte_of((op_ff == OP_OTP_PROTECT) ? PROTECT_ADDR : addr_ff,
					cnt_ff[1:0]);
			end
			S_DWR: begin
				iss_req.kind = CY_DWR;
				iss_en = (op_ff != OP_OTP_PROG) || tx_valid_ff;
				if (op_ff == OP_SET_FEAT) begin
					// only byte one carries the strength code, the rest stay zero
					iss_req.data = (cnt_ff == 12'h000) ? {6'h00, strength_ff} : 8'h00;
				end else begin
					iss_req.data = tx_data_ff;
				end
			end
			S_CONF: begin
				iss_req.data = (op_ff == OP_OTP_READ) ? CMD_CONFIRM_READ : CMD_CONFIRM_PROG;
			end
			S_RESTORE: begin
				iss_req.data = CMD_READ_MODE;
			end
			S_SRD: begin
				iss_req.kind = CY_DRD;
			end
			S_DRD: begin
				iss_req.kind = CY_DRD;
				iss_en = (op_ff != OP_DATA_READ) || !rx_valid_ff;
			end
			S_SCMD: begin
				iss_req.data = CMD_STATUS;
			end
			default: begin
				iss_en = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// operation sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= S_IDLE;
			op_ff <= OP_NONE;
			wp_n_ff <= 1'b0;
			ce_n_ff <= 1'b1;
			poll_ff <= 1'b0;
			poll_phase_ff <= 1'b0;
			err_ff <= 1'b0;
			feat_mode_ff <= 1'b0;
			need_restore_ff <= 1'b0;
			stat_ff <= 8'h00;
			feat_rd_ff <= 32'h0000_0000;
			rx_data_ff <= 8'h00;
			cnt_ff <= 12'h000;
			timer_ff <= 16'h0000;
			pend_ff <= 1'b0;
			cy_start_ff <= 1'b0;
			cy_req_ff <= '{kind: CY_CMD, data: 8'h00};
			for (int i = 0; i < OTP_PAGES; i++) begin
				part_ff[i] <= 3'h0;
			end
		end else begin
			cy_start_ff <= 1'b0;
			if (iss_en && !pend_ff && state_ff != S_IDLE) begin
				cy_start_ff <= 1'b1;
				cy_req_ff <= iss_req;
				pend_ff <= 1'b1;
			end
			if (cy_done) begin
				pend_ff <= 1'b0;
			end
			case (state_ff)
				S_IDLE: begin
					if (start_go) begin
						err_ff <= !start_ok;
						if (start_ok) begin
							op_ff <= nfo_op_e'(wb_dat_i[3:0]);
							poll_ff <= wb_dat_i[CTRL_POLL];
							ce_n_ff <= 1'b0;
							cnt_ff <= 12'h000;
							if (nfo_op_e'(wb_dat_i[3:0]) == OP_OTP_PROG) begin
								part_ff[page_idx[3:0]] <= part_ff[page_idx[3:0]] + 3'h1;
							end
							// protect level changes only between operations
							if (wp_n_ff != wp_en_ff) begin
								wp_n_ff <= wp_en_ff;
								timer_ff <= WP_SETUP;
								state_ff <= S_WP;
							end else if (nfo_op_e'(wb_dat_i[3:0]) == OP_DATA_READ && !need_restore_ff) begin
								state_ff <= S_DRD;
							end else begin
								state_ff <= S_CMD;
							end
						end
					end
				end
				S_WP: begin
					timer_ff <= timer_ff - 16'h0001;
					if (timer_ff == 16'h0000) begin
						state_ff <= (op_ff == OP_DATA_READ && !need_restore_ff) ? S_DRD : S_CMD;
					end
				end
				S_CMD: begin
					if (cy_done) begin
						feat_mode_ff <= (op_ff == OP_GET_FEAT) || (op_ff == OP_SET_FEAT);
						need_restore_ff <= (op_ff == OP_STATUS);
						timer_ff <= SETTLE;
						case (op_ff)
							OP_STATUS: state_ff <= S_SRD;
							OP_RESET: state_ff <= S_SETTLE;
							OP_DATA_READ: state_ff <= S_DRD;
							default: state_ff <= S_ADDR;
						endcase
					end
				end
				S_ADDR: begin
					if (cy_done) begin
						cnt_ff <= cnt_ff + 12'h001;
						if (cnt_ff == n_addr - 12'h001) begin
							cnt_ff <= 12'h000;
							timer_ff <= SETTLE;
							if (op_ff == OP_SET_FEAT || op_ff == OP_OTP_PROG) begin
								state_ff <= S_DWR;
							end else if (op_ff == OP_GET_FEAT) begin
								state_ff <= S_SETTLE;
							end else begin
								state_ff <= S_CONF;
							end
						end
					end
				end
				S_DWR: begin
					if (cy_done) begin
						cnt_ff <= cnt_ff + 12'h001;
						if (cnt_ff == n_data - 12'h001) begin
							timer_ff <= SETTLE;
							state_ff <= (op_ff == OP_SET_FEAT) ? S_SETTLE : S_CONF;
						end
					end
				end
				S_CONF: begin
					if (cy_done) begin
						timer_ff <= SETTLE;
						state_ff <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					timer_ff <= timer_ff - 16'h0001;
					if (timer_ff == 16'h0000) begin
						timer_ff <= RST_WAIT;
						poll_phase_ff <= poll_ff && (op_ff != OP_RESET);
						state_ff <= (poll_ff && op_ff != OP_RESET) ? S_SCMD : S_WAIT;
					end
				end
				S_WAIT: begin
					timer_ff <= timer_ff - 16'h0001;
					// a reset is given up to its full recovery time
					if (rb_ready || (op_ff == OP_RESET && timer_ff == 16'h0000)) begin
						cnt_ff <= 12'h000;
						if (op_ff == OP_GET_FEAT) begin
							state_ff <= need_restore_ff ? S_RESTORE : S_DRD;
						end else if (op_ff == OP_OTP_PROG || op_ff == OP_OTP_PROTECT) begin
							state_ff <= S_SCMD;
						end else begin
							ce_n_ff <= 1'b1;
							state_ff <= S_IDLE;
						end
					end
				end
				S_SCMD: begin
					if (cy_done) begin
						need_restore_ff <= 1'b1;
						state_ff <= S_SRD;
					end
				end
				S_SRD: begin
					if (cy_done) begin
						stat_ff <= cy_rdata;
						if (poll_phase_ff && !cy_rdata[SR_READY]) begin
							state_ff <= S_SRD;
						end else if (poll_phase_ff) begin
							poll_phase_ff <= 1'b0;
							state_ff <= S_WAIT;
							timer_ff <= 16'h0000;
						end else begin
							ce_n_ff <= 1'b1;
							state_ff <= S_IDLE;
						end
					end
				end
				S_RESTORE: begin
					if (cy_done) begin
						need_restore_ff <= 1'b0;
						state_ff <= S_DRD;
					end
				end
				S_DRD: begin
					if (cy_done) begin
						cnt_ff <= cnt_ff + 12'h001;
						if (op_ff == OP_GET_FEAT) begin
							feat_rd_ff[8*cnt_ff[1:0] +: 8] <= cy_rdata;
						end else begin
							rx_data_ff <= cy_rdata;
						end
						if (cnt_ff == n_data - 12'h001) begin
							ce_n_ff <= 1'b1;
							state_ff <= S_IDLE;
						end
					end
				end
				default: begin
					state_ff <= S_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// software data handshakes, set wins over clear
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_valid_ff <= 1'b0;
			tx_data_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
		end else begin
			if (bus_wr && wb_adr_i[7:0] == REG_TXDATA && wb_sel_i[0]) begin
				tx_valid_ff <= 1'b1;
				tx_data_ff <= wb_dat_i[7:0];
			end else if (tx_take) begin
				tx_valid_ff <= 1'b0;
			end
			if (rx_load) begin
				rx_valid_ff <= 1'b1;
			end else if (bus_rd && wb_adr_i[7:0] == REG_RXDATA) begin
				rx_valid_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ack_ff <= 1'b0;
			rd_ff <= 32'h0000_0000;
			addr_ff <= 32'h0000_0000;
			len_ff <= 12'h000;
			strength_ff <= STRENGTH_FULL;
			wp_en_ff <= 1'b0;
		end else begin
			ack_ff <= bus_hit;
			if (bus_wr && state_ff == S_IDLE) begin
				if (wb_adr_i[7:0] == REG_ADDR) begin
					addr_ff <= lanes(addr_ff, wb_dat_i, wb_sel_i);
				end else if (wb_adr_i[7:0] == REG_LEN) begin
					len_ff <= 12'(lanes({20'h00000, len_ff}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i[7:0] == REG_FEAT && wb_sel_i[0]) begin
					strength_ff <= wb_dat_i[1:0];
				end else if (wb_adr_i[7:0] == REG_WP && wb_sel_i[0]) begin
					wp_en_ff <= wb_dat_i[WP_ENABLE];
				end
			end
			if (bus_rd) begin
				if (wb_adr_i[7:0] == REG_ADDR) begin
					rd_ff <= addr_ff;
				end else if (wb_adr_i[7:0] == REG_LEN) begin
					rd_ff <= {20'h00000, len_ff};
				end else if (wb_adr_i[7:0] == REG_FEAT) begin
					rd_ff <= feat_rd_ff;
				end else if (wb_adr_i[7:0] == REG_RXDATA) begin
					rd_ff <= {24'h000000, rx_data_ff};
				end else if (wb_adr_i[7:0] == REG_STATUS) begin
					rd_ff <= {16'h0000, stat_ff, stat_ff[SR_PASS_FAIL], ~stat_ff[SR_UNPROT], wp_n_ff,
						feat_mode_ff, err_ff, rx_valid_ff, ~tx_valid_ff, state_ff != S_IDLE};
				end else if (wb_adr_i[7:0] == REG_WP) begin
					rd_ff <= {31'h0, wp_en_ff};
				end else begin
					rd_ff <= 32'h0000_0000;
				end
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;
	assign nand_ce_n = ce_n_ff;
	assign nand_cle = strobe.cle;
	assign nand_ale = strobe.ale;
	assign nand_we_n = strobe.we_n;
	assign nand_re_n = strobe.re_n;
	assign nand_wp_n = wp_n_ff;
endmodule

// [verification/nfo_ctrl_assertions.sv]
// nfo_ctrl_chk: port checks for the controller
`timescale 1ns/1ps
module nfo_ctrl_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic nand_ce_n,
	input wire logic nand_cle,
	input wire logic nand_ale,
	input wire logic nand_we_n,
	input wire logic nand_re_n,
	input wire logic nand_wp_n,
	input wire logic nand_io_oe
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] wp_cnt_ff;
	// saturates so a long idle spell never wraps to a false setup miss
	always_ff @(posedge clk) begin
		if (!reset_n) wp_cnt_ff <= 8'hFF;
		else if ($changed(nand_wp_n)) wp_cnt_ff <= 8'h00;
		else if (wp_cnt_ff != 8'hFF) wp_cnt_ff <= wp_cnt_ff + 8'h01;
	end
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_wr; !nand_we_n[*5] ##1 nand_we_n; endsequence
	sequence s_rd; !nand_re_n[*7] ##1 nand_re_n; endsequence
	property p_ack; s_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_wr; $fell(nand_we_n) |-> s_wr; endproperty
	property p_rd; $fell(nand_re_n) |-> s_rd; endproperty
	property p_latch; !(nand_cle && nand_ale); endproperty
	property p_drv; (nand_cle || nand_ale) && !nand_we_n |-> nand_io_oe; endproperty
	property p_dir; !nand_re_n |-> !nand_io_oe && nand_we_n; endproperty
	property p_ce; !nand_we_n || !nand_re_n |-> !nand_ce_n; endproperty
	property p_wp; $fell(nand_we_n) |-> wp_cnt_ff >= 8'h18; endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	a_wr: assert property (p_wr) else $error("write strobe width");
	a_rd: assert property (p_rd) else $error("read strobe width");
	a_latch: assert property (p_latch) else $error("both latch enables");
	a_drv: assert property (p_drv) else $error("bus not driven");
	a_dir: assert property (p_dir) else $error("bus fight on read");
	a_ce: assert property (p_ce) else $error("strobe without chip enable");
	a_wp: assert property (p_wp) else $error("protect pin setup");
endmodule

// [verification/nfo_dev_model.sv]
// nfo_dev_model: behavioural flash answering feature and one-time-area commands
`timescale 1ns/1ps
module nfo_dev_model import nfo_pkg::*; (
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic wp_n,
	input wire logic [7:0] io_o,
	output logic [7:0] io_i,
	output logic rb
);
	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	logic [7:0] feat [2][4] = '{default: 8'h00}; // power-on full strength
	logic [7:0] op = 8'h00;
	logic [7:0] fa = 8'h80;
	logic [31:0] ad = 32'h0000_0000;
	logic [7:0] otp [OTP_PAGES][OTP_PAGE_BYTES] = '{default: 8'hFF}; // ships erased
	logic prot = 1'b0;
	logic smode = 1'b0;
	int nd = 0;
	int nr = 0;
	initial io_i = 8'h5A;
	initial rb = 1'b1;
	task automatic go(input int t);
		rb <= 1'b0;
		rb <= #(t) 1'b1;
	endtask
	always @(posedge we_n) if (!ce_n) begin
		if (cle) begin
			smode = (io_o == CMD_STATUS);
			nr = 0;
			if (io_o == CMD_CONFIRM_PROG) begin
				prot |= (op == CMD_OTP_PROTECT) && wp_n;
				go((op == CMD_OTP_PROG && prot) ? 40 : 400);
			end else if (io_o == CMD_CONFIRM_READ) go(400);
			else if (!smode && io_o != CMD_READ_MODE) op = io_o;
		end else if (ale) begin
			fa = io_o;
			ad = {io_o, ad[31:8]};
			nd = 0;
			if (op == CMD_GET_FEAT) go(400);
		end else if (op == CMD_SET_FEAT) begin
			feat[fa[0]][nd] = (nd == 0) ? {6'h00, io_o[1:0]} : 8'h00;
			nd++;
			if (nd == 4) go(400);
		end else if (op == CMD_OTP_PROG && !prot && wp_n) begin
			otp[ad[23:16] - OTP_FIRST_PAGE][ad[11:0] + nd] &= io_o;
			nd++;
		end
	end
	always @(negedge re_n) if (!ce_n) begin
		// bit0 stays low: an and-only program never leaves a wanted zero at one
		if (smode) io_i = {~prot, rb, rb, 5'h00};
		else if (op == CMD_GET_FEAT) io_i = feat[fa[0]][nr[1:0]];
		else if (op == CMD_OTP_READ) begin
			io_i = otp[ad[23:16] - OTP_FIRST_PAGE][ad[11:0] + nr];
		end
		else io_i = 8'hFF;
		nr++;
	end
	// released bus shows the inverse so a stale byte is never mistaken for data
	always @(posedge re_n) io_i = ~io_i;
endmodule

// [verification/tb.sv]
// tb: self-checking bench for the feature and one-time-area controller
`timescale 1ns/1ps
module tb import nfo_pkg::*; ;
	logic clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic ack, ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb;
	logic [7:0] io_o, io_i;
	int n_fail = 0, n_checks = 0;
	always #2 clk = ~clk;
	nfo_ctrl nfo_ctrl_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
		.nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(io_oe),
		.nand_io_i(io_i), .ready_busy_n(rb));
	nfo_dev_model nfo_dev_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
		.re_n(re_n), .wp_n(wp_n), .io_o(io_o), .io_i(io_i), .rb(rb));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic go_op(input logic [7:0] code, input logic [31:0] a);
		wb(1'b1, REG_ADDR, a);
		wb(1'b1, REG_CTRL, {24'h0, code});
	endtask
	task automatic idle;
		rdat = 32'h1;
		while (rdat[0] !== 1'b0) wb(1'b0, REG_STATUS, 32'h0);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rdat & 32'h29, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(rdat, 32'h0);
	endtask
	task automatic t_feat;
		go_op(8'h01, {24'h0, FEAT_ADDR_DRIVE});
		idle;
		wb(1'b0, REG_FEAT, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, REG_FEAT, 32'h3);
		go_op(8'h02, {24'h0, FEAT_ADDR_PULLDOWN});
		idle;
		go_op(8'h11, {24'h0, FEAT_ADDR_PULLDOWN});
		idle;
		wb(1'b0, REG_FEAT, 32'h0);
		chk(rdat, 32'h3);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rdat & 32'h10, 32'h10);
		go_op(8'h07, 32'h0);
		idle;
		chk(rdat & 32'h10, 32'h0);
	endtask
	task automatic t_bad;
		go_op(8'h01, 32'h82);
		idle;
		chk(rdat & 32'h8, 32'h8);
	endtask
	task automatic t_prot;
		go_op(8'h04, PROTECT_ADDR);
		idle;
		chk(rdat & 32'hE0, 32'h00);
		wb(1'b1, REG_WP, 32'h1);
		wb(1'b1, REG_LEN, 32'h1);
		go_op(8'h03, 32'h0002_0000);
		wb(1'b1, REG_TXDATA, 32'h3C);
		idle;
		chk(rdat & 32'hE0, 32'h20);
		go_op(8'h04, PROTECT_ADDR);
		idle;
		chk(rdat & 32'hE0, 32'h60);
		go_op(8'h03, 32'h0002_0000);
		wb(1'b1, REG_TXDATA, 32'h0);
		idle;
		chk(rdat & 32'h40, 32'h40);
		go_op(8'h04, PROTECT_ADDR);
		idle;
		chk(rdat & 32'hE0, 32'h60);
		go_op(8'h05, 32'h0002_0000);
		idle;
		go_op(8'h08, 32'h0002_0000);
		idle;
		wb(1'b0, REG_RXDATA, 32'h0);
		chk(rdat, 32'h3C);
		go_op(8'h06, 32'h0);
		idle;
		chk(rdat & 32'hFF00, 32'h6000);
	endtask
	initial begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		t_reset;
		t_feat;
		t_bad;
		t_prot;
		stop_test;
	end
endmodule
bind nfo_ctrl nfo_ctrl_chk nfo_ctrl_chk_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle),
	.nand_ale(nand_ale), .nand_we_n(nand_we_n), .nand_re_n(nand_re_n),
	.nand_wp_n(nand_wp_n), .nand_io_oe(nand_io_oe));
